/* src/exec_slice_pkg.sv */
// Package: encodings, widths and reset values of the execution slice
package exec_slice_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    // Opcode patterns and masks
    localparam logic [13:0] CLEAR_MASK = 14'h3f80;
    localparam logic [13:0] CLEAR_CODE = 14'h0180;
    localparam logic [13:0] SWAP_MASK = 14'h3f00;
    localparam logic [13:0] SWAP_CODE = 14'h0e00;
    localparam logic [13:0] CALL_MASK = 14'h3800;
    localparam logic [13:0] CALL_CODE = 14'h2000;
    localparam logic [13:0] BTSS_MASK = 14'h3c00;
    localparam logic [13:0] BTSS_CODE = 14'h1c00;
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int BIT_SEL_LSB = 7;
    localparam int CALL_K_W = 11;
    localparam int LATCH_HI_LSB = 3;
    // Reset values and the return-address increment
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [12:0] PC_ONE = 13'h0001;
    typedef enum logic [1:0] {
        EXEC_RUN,
        EXEC_FLUSH
    } exec_state_t;
endpackage

/* src/clear_swap_call_exec.sv */
// Execution slice: clear, nibble swap, call and bit-test-skip
`timescale 1ns/10ps
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
module clear_swap_call_exec (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [12:0] instr_addr_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [7:0] pc_high_latch_in,
    output logic [6:0] file_addr_out,
    output logic file_we_out,
    output logic [7:0] file_wdata_out,
    output logic acc_we_out,
    output logic [7:0] acc_wdata_out,
    output logic zero_flag_we_out,
    output logic zero_flag_out,
    output logic push_out,
    output logic [12:0] stack_top_out,
    output logic pc_load_out,
    output logic [12:0] pc_target_out,
    output logic fetch_discard_out,
    output logic busy_out
);
    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    exec_slice_pkg::exec_state_t state;
    logic is_clr;
    logic is_swap;
    logic is_call;
    logic is_btss;
    logic accept;
    logic [2:0] bit_sel;
    logic [7:0] swapped;
    logic bit_set;
    logic skip_taken;
    logic two_cycle;

    // Nothing is taken in the second cycle of a two-cycle instruction
    assign accept = instr_valid_in && (state == exec_slice_pkg::EXEC_RUN);
    assign is_clr = accept && ((instr_in & exec_slice_pkg::CLEAR_MASK)
                    == exec_slice_pkg::CLEAR_CODE);
    assign is_swap = accept && ((instr_in & exec_slice_pkg::SWAP_MASK)
                     == exec_slice_pkg::SWAP_CODE);
    assign is_call = accept && ((instr_in & exec_slice_pkg::CALL_MASK)
                     == exec_slice_pkg::CALL_CODE);
    assign is_btss = accept && ((instr_in & exec_slice_pkg::BTSS_MASK)
                     == exec_slice_pkg::BTSS_CODE);

    //------------------------------------------------------------------
    // Operand bit test
    //------------------------------------------------------------------
    assign bit_sel = instr_in[exec_slice_pkg::BIT_SEL_LSB +: 3];
    assign bit_set = file_rdata_in[bit_sel];
    assign skip_taken = is_btss && bit_set;
    assign two_cycle = is_call || skip_taken;

    //------------------------------------------------------------------
    // Nibble exchange, one lane per bit of the low nibble
    //------------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_swap
        assign swapped[i] = file_rdata_in[i + 4];
        assign swapped[i + 4] = file_rdata_in[i];
    end

    //------------------------------------------------------------------
    // Register address
    //------------------------------------------------------------------
    // Register address is combinational from the instruction, so the
    // datapath read data is valid in the same cycle; the datapath
    // holds the write address for the following cycle itself
    assign file_addr_out = instr_in[exec_slice_pkg::ADDR_W-1:0];

    //------------------------------------------------------------------
    // Sequencer: second cycle of call or of a taken skip
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= exec_slice_pkg::EXEC_RUN;
        end else begin
            case (state)
                exec_slice_pkg::EXEC_RUN: begin
                    // A call or a taken skip spends one dead cycle
                    if (two_cycle) begin
                        state <= exec_slice_pkg::EXEC_FLUSH;
                    end
                end
                exec_slice_pkg::EXEC_FLUSH: begin
                    state <= exec_slice_pkg::EXEC_RUN;
                end
                default: begin
                    state <= exec_slice_pkg::EXEC_RUN;
                end
            endcase
        end
    end


    //------------------------------------------------------------------
    // Second-cycle flag
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= two_cycle;
        end
    end

    //------------------------------------------------------------------
    // Discard of the already fetched word
    //------------------------------------------------------------------
    // The fetch stage runs a no-operation in place of the dropped word
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fetch_discard_out <= 1'b0;
        end else begin
            fetch_discard_out <= two_cycle;
        end
    end

    //------------------------------------------------------------------
    // File register write
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            file_we_out <= 1'b0;
            file_wdata_out <= exec_slice_pkg::DATA_RESET;
        end else begin
            file_we_out <= is_clr
                || (is_swap && instr_in[exec_slice_pkg::DEST_BIT]);
            // Data holds its last value except on a clear or any swap, including a swap into the accumulator
            if (is_clr) begin
                file_wdata_out <= exec_slice_pkg::DATA_RESET;
            end else if (is_swap) begin
                file_wdata_out <= swapped;
            end
        end
    end

    //------------------------------------------------------------------
    // Zero flag write
    //------------------------------------------------------------------
    // Flag value only counts while its write strobe is high; the
    // exchange leaves the flags untouched
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            zero_flag_we_out <= 1'b0;
            zero_flag_out <= 1'b0;
        end else begin
            zero_flag_we_out <= is_clr;
            zero_flag_out <= is_clr;
        end
    end

    //------------------------------------------------------------------
    // Accumulator write
    //------------------------------------------------------------------
    // Clear never touches the accumulator
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_we_out <= 1'b0;
            acc_wdata_out <= exec_slice_pkg::DATA_RESET;
        end else begin
            acc_we_out <= is_swap
                && !instr_in[exec_slice_pkg::DEST_BIT];
            if (is_swap) begin
                acc_wdata_out <= swapped;
            end
        end
    end

    //------------------------------------------------------------------
    // Call: push and load strobes
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            push_out <= 1'b0;
            pc_load_out <= 1'b0;
        end else begin
            push_out <= is_call;
            pc_load_out <= is_call;
        end
    end

    //------------------------------------------------------------------
    // Call: return address
    //------------------------------------------------------------------
    // Wraps at the top of program space like the counter itself
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stack_top_out <= exec_slice_pkg::PC_RESET;
        end else begin
            if (is_call) begin
                stack_top_out <= instr_addr_in
                    + exec_slice_pkg::PC_ONE;
            end
        end
    end

    //------------------------------------------------------------------
    // Call: target address
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_target_out <= exec_slice_pkg::PC_RESET;
        end else begin
            if (is_call) begin
                pc_target_out <= {
                    pc_high_latch_in[exec_slice_pkg::LATCH_HI_LSB +: 2],
                    instr_in[exec_slice_pkg::CALL_K_W-1:0]};
            end
        end
    end
endmodule // clear_swap_call_exec

/* bench/exec_slice_assertions.sv */
// Checker: port relations of the execution slice
`timescale 1ns/10ps
module exec_slice_checker (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [12:0] instr_addr_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [7:0] pc_high_latch_in,
    input wire logic file_we_out,
    input wire logic [7:0] file_wdata_out,
    input wire logic acc_we_out,
    input wire logic [7:0] acc_wdata_out,
    input wire logic zero_flag_out,
    input wire logic [12:0] stack_top_out,
    input wire logic [12:0] pc_target_out,
    input wire logic fetch_discard_out,
    input wire logic busy_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    wire go = instr_valid_in && !busy_out;
    wire clr = go && (instr_in & 14'h3f80) == 14'h0180;
    wire swp = go && (instr_in & 14'h3f00) == 14'h0e00;
    wire cal = go && (instr_in & 14'h3800) == 14'h2000;
    wire skp = go && (instr_in & 14'h3c00) == 14'h1c00;
    wire [7:0] sw = {file_rdata_in[3:0], file_rdata_in[7:4]};
    wire bitv = file_rdata_in[instr_in[9:7]];
    sequence s_call_done;
        busy_out && fetch_discard_out
            && stack_top_out == $past(instr_addr_in) + 13'h0001 ##1 !busy_out;
    endsequence
    property p_clr; clr |=> file_we_out && !file_wdata_out && zero_flag_out;
    endproperty
    property p_swap;
        swp |=> (acc_we_out ? acc_wdata_out : file_wdata_out) == $past(sw);
    endproperty
    property p_dest;
        swp |=> acc_we_out != $past(instr_in[7])
            && file_we_out == $past(instr_in[7]);
    endproperty
    property p_call; cal |=> s_call_done; endproperty
    property p_skip; skp |=> fetch_discard_out == $past(bitv); endproperty
    property p_target;
        cal |=> pc_target_out
            == {$past(pc_high_latch_in[4:3]), $past(instr_in[10:0])};
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear result wrong");
    a_swap: assert property (p_swap)
        else $error("swap data wrong");
    a_dest: assert property (p_dest)
        else $error("swap target wrong");
    a_call: assert property (p_call)
        else $error("call steps wrong");
    a_skip: assert property (p_skip)
        else $error("skip discard wrong");
    a_target: assert property (p_target)
        else $error("call pc wrong");
endmodule // exec_slice_checker
bind clear_swap_call_exec exec_slice_checker i_chk (.*);

/* bench/clear_swap_call_exec_test.sv */
// Testbench: corner and random instructions for the execution slice
`timescale 1ns/10ps
module clear_swap_call_exec_test;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [12:0] instr_addr_in = 13'h0000;
    logic [7:0] pc_high_latch_in = 8'h00;
    logic [7:0] regs [128];
    logic [6:0] file_addr_out;
    logic [7:0] file_wdata_out, acc_wdata_out, d, q;
    logic [12:0] stack_top_out, pc_target_out, t;
    logic [13:0] w, r;
    logic file_we_out, acc_we_out, zero_flag_we_out, zero_flag_out;
    logic push_out, pc_load_out, fetch_discard_out, busy_out;
    wire [7:0] file_rdata_in = regs[file_addr_out];
    int fail_count = 0;
    int comparisons = 0;
    clear_swap_call_exec i_dut (.*);
    always #10 ref_clk_in = ~ref_clk_in;
    function automatic logic [7:0] swap_exp(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction
    function automatic logic [12:0] target_exp(input logic [7:0] hi,
            input logic [10:0] k);
        return {hi[4:3], k};
    endfunction
    task automatic chk(input logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: output mismatch", $time);
        end
    endtask
    task automatic op(input logic [13:0] v);
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= v;
        instr_addr_in <= 13'($urandom);
        pc_high_latch_in <= 8'($urandom);
        #1 d = regs[v[6:0]];
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h036e));
        foreach (regs[k]) regs[k] = 8'($urandom);
        repeat (5) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        for (int n = 0; n < 48; n++) begin
            // First eight use all-zero and all-one operands
            r = (n < 8) ? {14{n[2]}} : 14'($urandom);
            case (n % 4)
                0: w = 14'h0180 | r[6:0];
                1: w = 14'h0e00 | r[7:0];
                2: w = 14'h2000 | r[10:0];
                default: w = 14'h1c00 | r[9:0];
            endcase
            op(w);
            case (n % 4)
                0: begin
                    chk(file_we_out && !file_wdata_out);
                    chk(zero_flag_we_out && zero_flag_out);
                end
                1: begin
                    q = w[7] ? file_wdata_out : acc_wdata_out;
                    chk(q === swap_exp(d));
                    chk(file_we_out === w[7]);
                    chk(acc_we_out === !w[7]);
                end
                2: begin
                    t = target_exp(pc_high_latch_in, w[10:0]);
                    chk(push_out && busy_out);
                    chk(stack_top_out === instr_addr_in + 13'h0001);
                    chk(pc_load_out && pc_target_out === t);
                    @(posedge ref_clk_in);
                    #1 chk(!busy_out && !push_out);
                end
                default: begin
                    chk(fetch_discard_out === d[w[9:7]]);
                    chk(busy_out === d[w[9:7]]);
                end
            endcase
        end
        $display("Instruction mix test done");
        // Clear offered in the dead cycle after a call is ignored
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= 14'h2155;
        @(posedge ref_clk_in);
        instr_in <= 14'h0185;
        #1 chk(busy_out && push_out);
        @(posedge ref_clk_in);
        instr_valid_in <= 1'b0;
        #1 chk(!file_we_out && !zero_flag_we_out && !busy_out);
        $display("Dead cycle test done");
        give_verdict();
    end
    // Watchdog: the tests need about 2300 ns, so this margin means a hang
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule // clear_swap_call_exec_test
